//--- src/parallel_port_cfg.svh
// Constants of the parallel port pin block: lane masks, reset values.
// Assumes eight ports of eight lanes each, packed as one 64-bit vector
// with port index p at bits [8p+7:8p]; indices 0..7 stand for the port
// groups zero, one, two, four, seven, eight, nine and eleven.
//
// Behaviour
// R1: Eight bidirectional ports, forty individually usable pins
// R2: Output data latched, input read path unlatched
// R3: Outside holds input stable or software resamples
// R4: Pin sampled in read cycle, no strobe
// R5: Written data reaches pins the next cycle
// R6: Output mode drives output data latch value
// R7: Input mode read returns present pin level
// R8: Direction bit: zero input, one output
// R9: Function bit one selects peripheral output source
// R10: Drive type bit selects push-pull or open-drain
// R11: Pull-up for input or open-drain pins
// R12: Lowest two oscillator port pins never general
// R13: Port zero doubles as oscillator pins
// R14: Port one feeds reset, interrupts, stop release
// R15: Port two shared with serial interfaces
// R16: Port four shared with analog, key wakeup
// R17: Port seven shared with timers, divider, interrupts
// R18: Reset leaves every pin input, alternate off
`ifndef PARALLEL_PORT_CFG_SVH
`define PARALLEL_PORT_CFG_SVH

// Lanes that exist at all (40 of 64)
`define IMPL_MASK  64'hf00303ffffff0f0f
// Lanes usable as general port pins (lowest two oscillator pins removed)
`define GEN_MASK   64'hf00303ffffff0f0c
// Lanes that own a drive type bit
`define DRV_MASK   64'hf003000000ff0000
// Lanes whose alternate peripheral output can reach the pin
`define ALT_MASK   64'hf00303ffffff0000
// Lanes that the low-frequency oscillator takes over
`define SUB_OSC_MASK 64'h000000000000000c
// Reset value of every control register
`define CTRL_RST   64'h0000000000000000

`endif

//--- src/parallel_port_pkg.sv
// Types shared by the parallel port pin block and its users.
// Assumes the core issues at most one register access of each kind a cycle.
package parallel_port_pkg;

  // Which per-port register an access addresses
  typedef enum logic [2:0] {
    SEL_DATA,
    SEL_LEVEL,
    SEL_DIR,
    SEL_ALT,
    SEL_DRV,
    SEL_PU
  } reg_sel_t;

  // Register write request from the core
  typedef struct packed {
    logic       en;
    logic [2:0] port;
    reg_sel_t   sel;
    logic [7:0] data;
  } reg_wr_t;

  // Register read request from the core
  typedef struct packed {
    logic       en;
    logic [2:0] port;
    reg_sel_t   sel;
  } reg_rd_t;

endpackage

//--- src/parallel_port_pin_control.sv
// Pin control for eight parallel ports: latches, direction, drive, pull-up.
// Assumes the core's register requests and peripheral outputs run on i_clk;
// pin levels arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`include "parallel_port_cfg.svh"

module parallel_port_pin_control
  import parallel_port_pkg::*;
#(
  parameter int LANES = 64
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Core register access
  input  wire reg_wr_t          i_wr,
  input  wire reg_rd_t          i_rd,
  output logic [7:0]            o_rd_data,
  output logic                  o_rd_valid,
  // Oscillator ownership
  input  wire logic             i_sub_osc_en,
  // Shared peripherals
  input  wire logic [LANES-1:0] i_alt_out,
  output logic [LANES-1:0]      o_periph_in,
  // Pins
  input  wire logic [LANES-1:0] i_pin_in,
  output logic [LANES-1:0]      o_pin_out,
  output logic [LANES-1:0]      o_pin_oe,
  output logic [LANES-1:0]      o_pullup_en
);

  // Lane masks from the header; they are 64 bits, so LANES must stay 64
  localparam logic [LANES-1:0] IMPL   = `IMPL_MASK;
  localparam logic [LANES-1:0] GEN    = `GEN_MASK;
  localparam logic [LANES-1:0] DRVM   = `DRV_MASK;
  localparam logic [LANES-1:0] ALTM   = `ALT_MASK;
  localparam logic [LANES-1:0] SUBOSC = `SUB_OSC_MASK;
  localparam logic [LANES-1:0] RSTV   = `CTRL_RST;

  // Control registers, one bit per lane
  logic [LANES-1:0] port_output_data_reg_r;       // Output latches
  logic [LANES-1:0] direction_select_reg_r;       // 1 = output
  logic [LANES-1:0] alternate_output_enable_reg_r; // 1 = peripheral drives
  logic [LANES-1:0] drive_type_select_reg_r;      // 1 = open-drain
  logic [LANES-1:0] pullup_select_reg_r;          // 1 = pull-up on
  // Next values, synchroniser stages and per-lane helpers
  logic [LANES-1:0] data_nxt;                     // Next output latches
  logic [LANES-1:0] dir_nxt;                      // Next direction
  logic [LANES-1:0] alt_nxt;                      // Next function select
  logic [LANES-1:0] drv_nxt;                      // Next drive type
  logic [LANES-1:0] pu_nxt;                       // Next pull-up select
  logic [LANES-1:0] pin_meta_r;                   // First sync stage
  logic [LANES-1:0] pin_level_r;                  // Second sync stage
  logic [LANES-1:0] wr_lanes;                     // Lanes of the write
  logic [LANES-1:0] wr_value;                     // Write data, replicated
  logic [LANES-1:0] out_nxt;                      // Next pin value
  logic [LANES-1:0] oe_nxt;                       // Next pin enable
  logic [LANES-1:0] pull_nxt;                     // Next pull-up enable
  logic [LANES-1:0] pin_level_read_reg;           // Readable pin levels

  // Byte lane of a 64-bit vector for one port index
  function automatic logic [7:0] byte_of(input logic [LANES-1:0] v,
                                         input logic [2:0] p);
    byte_of = v[{p, 3'b000} +: 8];
  endfunction

  // Decode the write into a lane mask; absent lanes stay zero so they read 0
  always_comb begin
    wr_lanes = '0;
    if (i_wr.en) begin
      wr_lanes[{i_wr.port, 3'b000} +: 8] = 8'hff;
    end
    wr_lanes = wr_lanes & IMPL;
    wr_value = {8{i_wr.data}};
  end

  // Next register values; a level write is ignored, the path has no latch
  always_comb begin
    data_nxt = port_output_data_reg_r;
    dir_nxt  = direction_select_reg_r;
    alt_nxt  = alternate_output_enable_reg_r;
    drv_nxt  = drive_type_select_reg_r;
    pu_nxt   = pullup_select_reg_r;
    case (i_wr.sel)
      SEL_DATA: begin // see R2
        data_nxt = (data_nxt & ~wr_lanes) | (wr_value & wr_lanes);
      end
      SEL_DIR: begin // see R8
        dir_nxt = (dir_nxt & ~wr_lanes) | (wr_value & wr_lanes);
      end
      SEL_ALT: begin // see R9
        alt_nxt = (alt_nxt & ~wr_lanes) | (wr_value & wr_lanes & ALTM);
      end
      SEL_DRV: begin // see R10
        drv_nxt = (drv_nxt & ~wr_lanes) | (wr_value & wr_lanes & DRVM);
      end
      SEL_PU: begin // see R11
        pu_nxt = (pu_nxt & ~wr_lanes) | (wr_value & wr_lanes);
      end
      default: begin
        // Level register and unused codes change nothing
      end
    endcase
  end

  // Control registers; reset makes every pin an input, see R18
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      port_output_data_reg_r        <= RSTV;
      direction_select_reg_r        <= RSTV;
      alternate_output_enable_reg_r <= RSTV;
      drive_type_select_reg_r       <= RSTV;
      pullup_select_reg_r           <= RSTV;
    end else begin
      port_output_data_reg_r        <= data_nxt;
      direction_select_reg_r        <= dir_nxt;
      alternate_output_enable_reg_r <= alt_nxt;
      drive_type_select_reg_r       <= drv_nxt;
      pullup_select_reg_r           <= pu_nxt;
    end
  end

  // Two-stage pin synchroniser; it does not filter chattering, so the
  // outside must hold data or software must resample, see R3
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_meta_r  <= '0;
      pin_level_r <= '0;
    end else begin
      pin_meta_r  <= i_pin_in;
      pin_level_r <= pin_meta_r;
    end
  end

  // Peripherals see every pin level: reset, interrupts, stop release,
  // serial, analog wakeup and timer inputs, see R14 R15 R16 R17
  assign o_periph_in = pin_level_r;

  // Per-lane pin driver; computed from next values so a write lands on
  // the pin one edge after the write cycle, see R1 R5
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic usable; // Lane free for general use
    logic src;    // Value presented to the pad
    logic drive;  // Lane in output mode
    logic od;     // Open-drain selected
    // Reserved oscillator lanes never drive, sub oscillator lanes only while it is off, see R12 R13
    assign usable = GEN[i] & ~(SUBOSC[i] & i_sub_osc_en);
    // Peripheral or latch as source, see R6 R9
    assign src    = (alt_nxt[i] & ALTM[i]) ? i_alt_out[i] : data_nxt[i];
    assign drive  = usable & dir_nxt[i]; // see R8
    assign od     = drv_nxt[i] & DRVM[i];
    // Open-drain only pulls low, see R10
    assign out_nxt[i]  = src;
    assign oe_nxt[i]   = drive & (~od | ~src);
    // Pull-up only for inputs and open-drain outputs, see R11
    assign pull_nxt[i] = usable & pu_nxt[i] & (~drive | od);
    // Readable level; reserved lanes read zero, see R7
    assign pin_level_read_reg[i] = pin_level_r[i] & GEN[i];
  end

  // Pad registers; all released during reset, see R18
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pin_out   <= '0;
      o_pin_oe    <= '0;
      o_pullup_en <= '0;
    end else begin
      o_pin_out   <= out_nxt;
      o_pin_oe    <= oe_nxt;
      o_pullup_en <= pull_nxt;
    end
  end

  // Read port; the level is taken in the read cycle itself, no strobe
  // leaves the block, see R4
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd.en;
      if (i_rd.en) begin
        case (i_rd.sel)
          SEL_DATA:  o_rd_data <= byte_of(port_output_data_reg_r, i_rd.port);
          SEL_LEVEL: o_rd_data <= byte_of(pin_level_read_reg, i_rd.port);
          SEL_DIR:   o_rd_data <= byte_of(direction_select_reg_r, i_rd.port);
          SEL_ALT: begin
            o_rd_data <= byte_of(alternate_output_enable_reg_r, i_rd.port);
          end
          SEL_DRV:   o_rd_data <= byte_of(drive_type_select_reg_r, i_rd.port);
          SEL_PU:    o_rd_data <= byte_of(pullup_select_reg_r, i_rd.port);
          default:   o_rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Pins are released right after reset
  chk_reset_all_inputs: assert property (@(posedge i_clk) // see R18
    $fell(i_sys_rst) |-> (o_pin_oe == '0) && (o_pullup_en == '0))
    else $error("pin driven or pulled right after reset");

  // Reserved oscillator lanes never drive
  chk_osc_lanes_idle: assert property (@(posedge i_clk) // see R12
    disable iff (i_sys_rst) o_pin_oe[1:0] == 2'b00)
    else $error("reserved oscillator lane driven");

  // Sub oscillator owns its two lanes
  chk_sub_osc_owns: assert property (@(posedge i_clk) // see R13
    disable iff (i_sys_rst) $past(i_sub_osc_en) |-> o_pin_oe[3:2] == 2'b00)
    else $error("sub oscillator lane driven");

  // Data written reaches the pins on the next edge
  chk_write_to_pin: assert property (@(posedge i_clk) // see R5
    disable iff (i_sys_rst)
    (i_wr.en && i_wr.sel == SEL_DATA && i_wr.port == 3'h3 &&
     alternate_output_enable_reg_r[31:24] == 8'h00)
    |=> o_pin_out[31:24] == $past(i_wr.data))
    else $error("written data missing on pins");

  // Enable needs output mode
  chk_dir_gates_oe: assert property (@(posedge i_clk) // see R8
    disable iff (i_sys_rst) (o_pin_oe & ~direction_select_reg_r) == '0)
    else $error("pin driven in input mode");

  // Level read returns synchronised pin level
  chk_level_read: assert property (@(posedge i_clk) // see R7
    disable iff (i_sys_rst)
    (i_rd.en && i_rd.sel == SEL_LEVEL && i_rd.port == 3'h2)
    |=> o_rd_valid && o_rd_data == $past(pin_level_r[23:16]))
    else $error("level read wrong");

  // Open-drain never drives high, on any lane
  chk_open_drain: assert property (@(posedge i_clk) // see R10
    disable iff (i_sys_rst)
    (o_pin_oe & drive_type_select_reg_r & o_pin_out) == '0)
    else $error("open-drain lane driven high");

  // Pull-up only in input or open-drain use
  chk_pullup_use: assert property (@(posedge i_clk) // see R11
    disable iff (i_sys_rst) o_pullup_en[16] |-> pullup_select_reg_r[16] &&
    (!direction_select_reg_r[16] || drive_type_select_reg_r[16]))
    else $error("pull-up on push-pull output");

  // Peripheral output follows through one register
  chk_alt_source: assert property (@(posedge i_clk) // see R9
    disable iff (i_sys_rst)
    (alternate_output_enable_reg_r[32] && direction_select_reg_r[32])
    |-> o_pin_out[32] == $past(i_alt_out[32]) && o_pin_oe[32])
    else $error("peripheral output not on pin");

  // Alternate enables exist only on lanes with a peripheral source
  chk_alt_mask_reg: assert property (@(posedge i_clk) // see R9
    disable iff (i_sys_rst)
    (alternate_output_enable_reg_r & ~ALTM) == '0)
    else $error("alternate enable on lane without source");

  // Drive type bits exist only on lanes that own one
  chk_drv_mask_reg: assert property (@(posedge i_clk) // see R10
    disable iff (i_sys_rst)
    (drive_type_select_reg_r & ~DRVM) == '0)
    else $error("drive type bit on lane without one");

  // Neither reserved nor absent lanes are ever driven or pulled up
  chk_oe_general_only: assert property (@(posedge i_clk) // see R1 R12
    disable iff (i_sys_rst)
    ((o_pin_oe | o_pullup_en) & ~GEN) == '0)
    else $error("reserved or absent lane active");

  // A write to the level register leaves the data and direction latches alone
  chk_level_write_void: assert property (@(posedge i_clk) // see R2
    disable iff (i_sys_rst)
    (i_wr.en && i_wr.sel == SEL_LEVEL)
    |=> $stable(port_output_data_reg_r) && $stable(direction_select_reg_r))
    else $error("level write changed a latch");

  // Read answer comes exactly one cycle after the request
  chk_read_answer_timing: assert property (@(posedge i_clk) // see R4
    disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> o_rd_valid == $past(i_rd.en))
    else $error("read valid not one cycle after request");

  // Read data holds between reads
  chk_read_data_hold: assert property (@(posedge i_clk) // see R4
    disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(i_rd.en)) |-> $stable(o_rd_data))
    else $error("read data changed without a read");

  // Peripherals and the level path see the pin two edges late
  chk_pin_sync_delay: assert property (@(posedge i_clk) // see R14 R17
    disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(i_sys_rst, 2))
    |-> o_periph_in == $past(i_pin_in, 2))
    else $error("pin level not two edges late");

  // Push-pull output lane without peripheral shows its latch
  chk_latch_on_pin: assert property (@(posedge i_clk) // see R6
    disable iff (i_sys_rst)
    (direction_select_reg_r[24] && !alternate_output_enable_reg_r[24])
    |-> o_pin_oe[24] && o_pin_out[24] == port_output_data_reg_r[24])
    else $error("latch value missing on output lane");

endmodule // parallel_port_pin_control

//--- tb/pin_side_model.sv
// Pad side of the port: outside drivers, pull-ups and floating pads.
// Assumes the bench says which lanes are driven from outside, and how.
`timescale 1ns/100ps
module pin_side_model (
  // Clock
  input  wire logic        i_clk,
  // Pad controls from the block
  input  wire logic [63:0] i_pad_out,
  input  wire logic [63:0] i_pad_oe,
  input  wire logic [63:0] i_pad_pu,
  // Outside drivers set by the bench
  input  wire logic [63:0] i_ext_lvl,
  input  wire logic [63:0] i_ext_en,
  // Resolved pad level
  output logic [63:0]      o_pin
);
  // A pad nobody drives wanders, so a stale value never passes for a read
  logic [63:0] flip_r = 64'h5a5a_5a5a_5a5a_5a5a;

  // Floating pattern changes every cycle
  always_ff @(posedge i_clk) flip_r <= ~flip_r;

  // Outside levels hold still between bench updates, long enough to read
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (i_pad_oe[i]) o_pin[i] = i_pad_out[i];
      else if (i_ext_en[i]) o_pin[i] = i_ext_lvl[i];
      else if (i_pad_pu[i]) o_pin[i] = 1'b1;
      else o_pin[i] = flip_r[i];
    end
  end
endmodule // pin_side_model

//--- tb/tb_parallel_port_pin_control.sv
// Self-checking bench of the parallel port pin block.
// Assumes the pad model resolves every pin level from both sides.
`timescale 1ns/100ps
`include "parallel_port_cfg.svh"
module tb_parallel_port_pin_control;
  import parallel_port_pkg::*;
  logic        i_clk, i_sys_rst, i_sub_osc_en, o_rd_valid;
  reg_wr_t     i_wr;
  reg_rd_t     i_rd;
  logic [7:0]  o_rd_data, d, r;
  logic [63:0] i_alt_out, o_periph_in, i_pin_in, o_pin_out;
  logic [63:0] o_pin_oe, o_pullup_en, ext_lvl, ext_en;
  logic [63:0] gen = `GEN_MASK;
  logic [63:0] impl = `IMPL_MASK;
  int          n_errors = 0, checks = 0, seed = 77, p;

  parallel_port_pin_control dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .i_sub_osc_en(i_sub_osc_en), .i_alt_out(i_alt_out),
    .o_periph_in(o_periph_in), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en));
  pin_side_model model (.i_clk(i_clk), .i_pad_out(o_pin_out),
    .i_pad_oe(o_pin_oe), .i_pad_pu(o_pullup_en), .i_ext_lvl(ext_lvl),
    .i_ext_en(ext_en), .o_pin(i_pin_in));

  // Byte of general lanes, and of existing lanes, of one port
  function automatic logic [7:0] gb(input int q);
    return gen[8*q +: 8];
  endfunction
  function automatic logic [7:0] ib(input int q);
    return impl[8*q +: 8];
  endfunction
  // Drive enable: output mode, and push-pull or a low value
  function automatic logic [7:0] exp_oe(input logic [7:0] dr, dt, ty, m);
    return dr & m & (~ty | ~dt);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write stays asserted; back to back writes are legal
  task automatic wr(input int q, input reg_sel_t s, input logic [7:0] x);
    i_wr = '{1'b1, 3'(q), s, x};
    @(negedge i_clk);
  endtask
  // Answer lands one cycle after the request
  task automatic rd(input int q, input reg_sel_t s, input logic [7:0] exp);
    i_rd = '{1'b1, 3'(q), s};
    @(negedge i_clk);
    chk({7'h00, o_rd_valid}, 8'h01);
    chk(o_rd_data, exp);
  endtask
  task automatic settle;
    i_wr.en = 1'b0;
    i_rd.en = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic chk_rst;
    for (int q = 0; q < 8; q++) begin
      chk(o_pin_oe[8*q +: 8], 8'h00);
      chk(o_pullup_en[8*q +: 8], 8'h00);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Free running clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  initial begin
    #(40 * 5000);
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_sub_osc_en = 1'b0;
    i_wr = '0;
    i_rd = '0;
    i_alt_out = '0;
    ext_lvl = '0;
    ext_en = '0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    chk_rst();
    for (p = 0; p < 8; p++) rd(p, SEL_ALT, 8'h00);
    // Random data and direction, push-pull, checked the cycle after
    for (int n = 0; n < 40; n++) begin
      p = $unsigned($random(seed)) % 8;
      d = 8'($random(seed));
      r = 8'($random(seed));
      wr(p, SEL_DATA, d);
      wr(p, SEL_DIR, r);
      settle();
      chk(o_pin_oe[8*p +: 8], exp_oe(r, d, 8'h00, gb(p)));
      chk(o_pin_out[8*p +: 8] & gb(p), d & gb(p));
      rd(p, SEL_DIR, r & ib(p));
    end
    // All inputs: reads follow the pads with no latch
    for (p = 0; p < 8; p++) wr(p, SEL_DIR, 8'h00);
    settle();
    ext_en = '1;
    for (int n = 0; n < 2; n++) begin
      ext_lvl = {$random(seed), $random(seed)};
      repeat (3) @(negedge i_clk);
      for (p = 0; p < 8; p++) begin
        rd(p, SEL_LEVEL, ext_lvl[8*p +: 8] & gb(p));
        chk(o_periph_in[8*p +: 8] & ib(p),
            ext_lvl[8*p +: 8] & ib(p));
      end
      settle();
    end
    // Open drain and pull-ups; outside lets go
    ext_en = '0;
    d = 8'($random(seed));
    wr(2, SEL_DATA, d);
    wr(2, SEL_DRV, 8'hf0);
    wr(2, SEL_DIR, 8'h3c);
    wr(2, SEL_PU, 8'hff);
    wr(1, SEL_PU, 8'hff);
    settle();
    chk(o_pin_oe[23:16], exp_oe(8'h3c, d, 8'hf0, 8'hff));
    chk(o_pullup_en[23:16], 8'hf3);
    chk(o_pullup_en[15:8], 8'h0f);
    repeat (2) @(negedge i_clk);
    rd(1, SEL_LEVEL, 8'h0f);
    // Readback; a level write and absent drive bits change nothing
    wr(2, SEL_LEVEL, ~d);
    wr(3, SEL_DRV, 8'hff);
    settle();
    rd(2, SEL_DATA, d);
    rd(2, SEL_DRV, 8'hf0);
    rd(3, SEL_DRV, 8'h00);
    rd(2, SEL_PU, 8'hff);
    // All lows: open-drain lanes sink as well
    wr(2, SEL_DATA, 8'h00);
    settle();
    chk(o_pin_oe[23:16], 8'h3c);
    chk(o_pin_out[23:16], 8'h00);
    // Peripheral drives port 7 lanes; port 0 has no such source
    i_alt_out = {$random(seed), $random(seed)};
    wr(4, SEL_ALT, 8'hff);
    wr(4, SEL_DIR, 8'hff);
    wr(0, SEL_ALT, 8'hff);
    settle();
    chk(o_pin_out[39:32], i_alt_out[39:32]);
    chk(o_pin_oe[39:32], 8'hff);
    rd(0, SEL_ALT, 8'h00);
    // Oscillator ownership of port 0 lanes
    wr(0, SEL_DIR, 8'hff);
    i_sub_osc_en = 1'b1;
    settle();
    chk(o_pin_oe[7:0], 8'h00);
    i_sub_osc_en = 1'b0;
    @(negedge i_clk);
    chk(o_pin_oe[7:0], 8'h0c);
    // Second reset in mid-run clears every drive
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    chk_rst();
    wrap_up();
  end
endmodule // tb_parallel_port_pin_control
